// ==== hw/akc_params.svh ====
`ifndef AKC_PARAMS_SVH
`define AKC_PARAMS_SVH
`define AKC_OFF_CTRL      8'h00
`define AKC_OFF_CONSOLE   8'h04
`define AKC_OFF_KEY       8'h08
`define AKC_OFF_SRC_ACC   8'h0C
`define AKC_OFF_DST_ACC   8'h10
`define AKC_OFF_MQ        8'h14
`define AKC_OFF_STATUS    8'h18
`define AKC_OFF_PC        8'h1C
`define AKC_OFF_SUM_HOLD  8'h20
`define AKC_OFF_MA        8'h24
`define AKC_OFF_MB        8'h28
`define AKC_OFF_SUM       8'h2C
`define AKC_C_SRC_LO      0
`define AKC_C_DST_LOW     2
`define AKC_C_DST_UHI     3
`define AKC_C_DST_LHI     4
`define AKC_C_SRC_INV     5
`define AKC_C_DST_INV     6
`define AKC_C_PLUS1       7
`define AKC_C_AND         8
`define AKC_C_MANIP_X     9
`define AKC_C_MANIP_Y     10
`define AKC_C_ALC         11
`define AKC_C_STORE       12
`define AKC_C_SKIP        13
`define AKC_C_LOAD_N      14
`define AKC_C_INC         15
`define AKC_C_SH_LOAD     16
`define AKC_C_C2M         17
`define AKC_C_A2M         18
`define AKC_C_MEMCY       19
`define AKC_K_EXAMINE     0
`define AKC_K_DEPOSIT     1
`define AKC_K_EXEC        2
`define AKC_CTRL_RST      32'h0000_4000
`define AKC_WORD_RST      16'h0000
`define AKC_TP_LAST       2'h3
`endif

// ==== hw/akc_pkg.sv ====
package akc_pkg;
    typedef enum logic [2:0] {
        AKC_IDLE = 3'b000,
        AKC_KEY  = 3'b001,
        AKC_CONSOLE_MEMORY_CYCLE = 3'b010,
        AKC_EXEC = 3'b011,
        AKC_MEMC = 3'b100
    } akc_state_t;
    typedef enum logic [1:0] {
        AKC_NONE  = 2'b00,
        AKC_LEFT  = 2'b01,
        AKC_RIGHT = 2'b10,
        AKC_SWAP  = 2'b11
    } akc_manip_t;
endpackage : akc_pkg

// ==== hw/akc_manip.sv ====
`timescale 1ns/1ps
`default_nettype none
module akc_manip #(
    parameter int DW = 16
) (
    input  wire logic [DW-1:0]     adder_res,
    input  wire logic              adder_carry,
    input  wire akc_pkg::akc_manip_t sel,
    output logic      [DW-1:0]     sum,
    output logic                   sum_carry
);
    import akc_pkg::*;
    always_comb begin
        sum       = adder_res;
        sum_carry = adder_carry;
        case (sel)
            AKC_NONE: begin
                sum       = adder_res;
                sum_carry = adder_carry;
            end
            AKC_LEFT: begin
                sum       = {adder_res[DW-2:0], adder_carry};
                sum_carry = adder_res[DW-1];
            end
            AKC_RIGHT: begin
                sum       = {adder_carry, adder_res[DW-1:1]};
                sum_carry = adder_res[0];
            end
            AKC_SWAP: begin
                sum       = {adder_res[DW/2-1:0], adder_res[DW-1:DW/2]};
                sum_carry = adder_carry;
            end
            default: begin
                sum       = adder_res;
                sum_carry = adder_carry;
            end
        endcase
    end
endmodule : akc_manip
`default_nettype wire

// ==== hw/akc_datapath.sv ====
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "akc_params.svh"
module akc_datapath #(
    parameter int DW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [DW-1:0] mem_sense_data,
    input  wire logic          data_channel_cycle,
    output logic [DW-2:0]      memory_address_reg,
    output logic [DW-1:0]      memory_buffer_reg,
    output logic [DW-1:0]      memory_output_bus,
    output logic               mem_strobe,
    output logic               buffer_load_pulse,
    output logic               mem_write,
    output logic               bus_transfer_inhibit_n,
    output logic               processor_running
);
    import akc_pkg::*;

    localparam int HB = DW / 2;

    logic [31:0]   ctrl_r;
    logic [DW-1:0] console_r;
    logic [DW-1:0] src_acc_r;
    logic [DW-1:0] dst_acc_r;
    logic [DW-1:0] mq_r;
    logic [DW-1:0] pc_r;
    logic [DW-1:0] sum_hold_r;
    logic [DW-2:0] ma_r;
    logic [DW-1:0] mb_r;
    logic [DW-1:0] mbo_r;
    logic          strobe_r;
    logic          bload_r;
    logic          mwr_r;
    logic          inh_n_r;
    logic          key_seen_r;
    logic          key_dep_r;
    logic          exec_req_r;
    logic          run_set_r;
    logic          run_r;
    logic [1:0]    phase_r;
    akc_state_t    state_r;
    logic          carry_r;
    logic [31:0]   prdata_r;
    logic          pready_r;
    logic          pslverr_r;

    // bus decode
    wire setup_rd  = psel && !penable;
    wire access    = psel && penable && pready_r;
    wire wr_ctrl   = access && pwrite && (paddr == `AKC_OFF_CTRL);
    wire wr_con    = access && pwrite && (paddr == `AKC_OFF_CONSOLE);
    wire wr_key    = access && pwrite && (paddr == `AKC_OFF_KEY);
    wire wr_sacc   = access && pwrite && (paddr == `AKC_OFF_SRC_ACC);
    wire wr_dacc   = access && pwrite && (paddr == `AKC_OFF_DST_ACC);
    wire wr_mq     = access && pwrite && (paddr == `AKC_OFF_MQ);
    wire idle      = (state_r == AKC_IDLE) && !key_seen_r && !exec_req_r;
    wire key_go    = wr_key && idle
                     && (pwdata[`AKC_K_EXAMINE] || pwdata[`AKC_K_DEPOSIT]);
    wire exec_go   = wr_key && idle && pwdata[`AKC_K_EXEC] && !key_go;

    // timing pulses
    wire tp0 = run_r && (phase_r == 2'h0);
    wire tp1 = run_r && (phase_r == 2'h1);
    wire tp2 = run_r && (phase_r == 2'h2);
    wire tp3 = run_r && (phase_r == `AKC_TP_LAST);

    wire in_key  = (state_r == AKC_KEY);
    wire in_console_memory_cycle = (state_r == AKC_CONSOLE_MEMORY_CYCLE);
    wire in_exec = (state_r == AKC_EXEC);
    wire in_memc = (state_r == AKC_MEMC);
    wire console_memory_cycle_dp = in_console_memory_cycle && key_dep_r;

    wire major_state_inhibit = in_key || in_console_memory_cycle || data_channel_cycle;
    wire c_on = in_exec && !major_state_inhibit;

    // operand selects
    wire       force_src_sh = console_memory_cycle_dp;
    wire [1:0] src_sel = force_src_sh ? 2'b01
                       : major_state_inhibit ? 2'b00
                       : ctrl_r[`AKC_C_SRC_LO +: 2];
    wire src_select_high = src_sel[1];
    wire src_select_low  = src_sel[0];
    wire mem_out         = in_key;
    wire forced_low_sel  = console_memory_cycle_dp;
    wire dst_sel_low  = (mem_out && !forced_low_sel) ? 1'b0
                      : console_memory_cycle_dp ? 1'b0 : ctrl_r[`AKC_C_DST_LOW];
    wire dst_upper_hi = (mem_out && !forced_low_sel) ? 1'b1
                      : console_memory_cycle_dp ? 1'b0 : ctrl_r[`AKC_C_DST_UHI];
    wire dst_lower_hi = (mem_out && !forced_low_sel) ? 1'b1
                      : console_memory_cycle_dp ? 1'b0 : ctrl_r[`AKC_C_DST_LHI];
    wire src_invert       = c_on && ctrl_r[`AKC_C_SRC_INV];
    wire dst_upper_invert = c_on && ctrl_r[`AKC_C_DST_INV];
    wire plus_one         = c_on && ctrl_r[`AKC_C_PLUS1];
    wire and_op           = c_on && ctrl_r[`AKC_C_AND];

    // console data rides the memory bus while transfer is inhibited
    wire [DW-1:0] mb_view = in_key ? console_r : mb_r;

    wire [DW-1:0] source_operand_mux =
        (src_select_high ? (src_select_low ? src_acc_r : pc_r)
                         : (src_select_low ? sum_hold_r : {DW{1'b0}}))
        ^ {DW{src_invert}};
    wire [HB-1:0] dst_upper_raw =
        dst_upper_hi ? (dst_sel_low ? dst_acc_r[DW-1:HB] : mb_view[DW-1:HB])
                     : (dst_sel_low ? mq_r[DW-1:HB] : {HB{1'b0}});
    wire [HB-1:0] dst_lower_raw =
        dst_lower_hi ? (dst_sel_low ? dst_acc_r[HB-1:0] : mb_view[HB-1:0])
                     : (dst_sel_low ? mq_r[HB-1:0] : {HB{1'b0}});
    wire [DW-1:0] dest_operand_mux =
        {dst_upper_raw ^ {HB{dst_upper_invert}}, dst_lower_raw};

    // adder
    wire [DW:0] add_full = {1'b0, source_operand_mux} + {1'b0, dest_operand_mux}
                         + {{DW{1'b0}}, plus_one};
    wire [DW-1:0] adder_res = and_op ? (source_operand_mux & dest_operand_mux)
                                     : add_full[DW-1:0];
    wire adder_carry = and_op ? 1'b0 : add_full[DW];

    // output manipulator
    wire alc_on = c_on && ctrl_r[`AKC_C_ALC];
    wire forced_manip_x = alc_on && ctrl_r[`AKC_C_MANIP_X];
    wire forced_manip_y = alc_on && ctrl_r[`AKC_C_MANIP_Y];
    wire akc_manip_t manip_sel = akc_manip_t'({forced_manip_y, forced_manip_x});
    wire [DW-1:0] sum;
    wire          sum_carry;

    akc_manip #(.DW(DW)) u_manip (
        .adder_res   (adder_res),
        .adder_carry (adder_carry),
        .sel         (manip_sel),
        .sum         (sum),
        .sum_carry   (sum_carry)
    );

    // counter and register load controls
    wire skip_on = in_exec && ctrl_r[`AKC_C_SKIP];
    wire counter_clock = in_exec && (tp1 || tp3);
    wire counter_load_n = !((in_key && !key_dep_r && tp2)
                         || (in_exec && tp3 && !ctrl_r[`AKC_C_LOAD_N] && !skip_on));
    wire counter_increment = counter_clock
                           && (skip_on || (tp3 && ctrl_r[`AKC_C_INC]));
    wire sum_hold_load = tp3 && ((in_key && key_dep_r)
                      || (in_exec && ctrl_r[`AKC_C_SH_LOAD]));
    wire counter_to_memory = in_key || (in_exec && ctrl_r[`AKC_C_C2M]);
    wire adder_to_mem = console_memory_cycle_dp || (in_exec && ctrl_r[`AKC_C_A2M]);
    wire [DW-1:0] mbo_nxt = counter_to_memory ? pc_r
                          : adder_to_mem ? sum : {DW{1'b0}};
    wire memory_cycle_pending = in_key || (in_exec && ctrl_r[`AKC_C_MEMCY]);
    wire address_load_pulse = tp3 && run_set_r && memory_cycle_pending;
    wire mem_cycle = in_console_memory_cycle || in_memc;
    wire omit_strobe = (in_console_memory_cycle && key_dep_r)
                    || (in_memc && ctrl_r[`AKC_C_STORE]);
    wire mb_from_bus = tp1 && (in_key || (mem_cycle && omit_strobe));
    wire halt_request = mem_cycle;

    // register read
    wire [31:0] status_w = {26'h0, carry_r, key_dep_r, exec_req_r || key_seen_r,
                            run_set_r, run_r, mem_cycle};
    wire rd_hit = (paddr[1:0] == 2'b00) && (paddr <= `AKC_OFF_SUM);
    wire [31:0] rd_mux =
        (paddr == `AKC_OFF_CTRL)     ? ctrl_r
      : (paddr == `AKC_OFF_CONSOLE)  ? {16'h0, console_r}
      : (paddr == `AKC_OFF_SRC_ACC)  ? {16'h0, src_acc_r}
      : (paddr == `AKC_OFF_DST_ACC)  ? {16'h0, dst_acc_r}
      : (paddr == `AKC_OFF_MQ)       ? {16'h0, mq_r}
      : (paddr == `AKC_OFF_STATUS)   ? status_w
      : (paddr == `AKC_OFF_PC)       ? {16'h0, pc_r}
      : (paddr == `AKC_OFF_SUM_HOLD) ? {16'h0, sum_hold_r}
      : (paddr == `AKC_OFF_MA)       ? {17'h0, ma_r}
      : (paddr == `AKC_OFF_MB)       ? {16'h0, mb_r}
      : (paddr == `AKC_OFF_SUM)      ? {15'h0, sum_carry, sum}
      : 32'h0000_0000;

    // bus slave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup_rd;
            pslverr_r <= setup_rd && !rd_hit;
            if (setup_rd && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r    <= `AKC_CTRL_RST;
            console_r <= `AKC_WORD_RST;
            src_acc_r <= `AKC_WORD_RST;
            dst_acc_r <= `AKC_WORD_RST;
            mq_r      <= `AKC_WORD_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= pwdata;
            if (wr_con)  console_r <= pwdata[DW-1:0];
            if (wr_sacc) src_acc_r <= pwdata[DW-1:0];
            if (wr_dacc) dst_acc_r <= pwdata[DW-1:0];
            if (wr_mq)   mq_r <= pwdata[DW-1:0];
        end
    end

    // counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= `AKC_WORD_RST;
        end else if (!counter_load_n) begin
            pc_r <= sum;
        end else if (counter_increment) begin
            pc_r <= pc_r + {{(DW-1){1'b0}}, 1'b1};
        end
    end

    // sum hold and carry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_hold_r <= `AKC_WORD_RST;
            carry_r    <= 1'b0;
        end else if (sum_hold_load) begin
            sum_hold_r <= sum;
            carry_r    <= sum_carry;
        end
    end

    // memory address, buffer and bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ma_r  <= {(DW-1){1'b0}};
            mb_r  <= `AKC_WORD_RST;
            mbo_r <= `AKC_WORD_RST;
        end else begin
            mbo_r <= mbo_nxt;
            if (address_load_pulse) ma_r <= mbo_nxt[DW-2:0];
            if (strobe_r) begin
                mb_r <= mem_sense_data;
            end else if (mb_from_bus) begin
                mb_r <= mbo_r;
            end
        end
    end

    // memory cycle pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_r <= 1'b0;
            bload_r  <= 1'b0;
            mwr_r    <= 1'b0;
            inh_n_r  <= 1'b1;
        end else begin
            strobe_r <= tp0 && mem_cycle && !omit_strobe;
            bload_r  <= mb_from_bus;
            mwr_r    <= tp2 && mem_cycle && omit_strobe;
            inh_n_r  <= !(key_seen_r || (run_r && in_key));
        end
    end

    // key and cycle sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= AKC_IDLE;
            key_seen_r <= 1'b0;
            key_dep_r  <= 1'b0;
            exec_req_r <= 1'b0;
            run_set_r  <= 1'b0;
            run_r      <= 1'b0;
            phase_r    <= 2'h0;
        end else begin
            if (run_r) phase_r <= phase_r + 2'h1;
            case (state_r)
                AKC_IDLE: begin
                    phase_r <= 2'h0;
                    if (key_go) begin
                        key_seen_r <= 1'b1;
                        key_dep_r  <= pwdata[`AKC_K_DEPOSIT] && !pwdata[`AKC_K_EXAMINE];
                    end else if (exec_go) begin
                        exec_req_r <= 1'b1;
                    end else if (key_seen_r) begin
                        key_seen_r <= 1'b0;
                        run_set_r  <= 1'b1;
                        run_r      <= 1'b1;
                        state_r    <= AKC_KEY;
                    end else if (exec_req_r) begin
                        exec_req_r <= 1'b0;
                        run_set_r  <= 1'b1;
                        run_r      <= 1'b1;
                        state_r    <= AKC_EXEC;
                    end
                end
                AKC_KEY: begin
                    if (tp3) state_r <= AKC_CONSOLE_MEMORY_CYCLE;
                end
                AKC_EXEC: begin
                    if (tp3 && memory_cycle_pending) begin
                        state_r <= AKC_MEMC;
                    end else if (tp3) begin
                        run_set_r <= 1'b0;
                        run_r     <= 1'b0;
                        state_r   <= AKC_IDLE;
                    end
                end
                AKC_CONSOLE_MEMORY_CYCLE, AKC_MEMC: begin
                    if (tp2 && halt_request) run_set_r <= 1'b0;
                    if (tp3 && !run_set_r) begin
                        run_r   <= 1'b0;
                        state_r <= AKC_IDLE;
                    end
                end
                default: begin
                    state_r <= AKC_IDLE;
                    run_r   <= 1'b0;
                end
            endcase
        end
    end

    assign prdata                 = prdata_r;
    assign pready                 = pready_r;
    assign pslverr                = pslverr_r;
    assign memory_address_reg     = ma_r;
    assign memory_buffer_reg      = mb_r;
    assign memory_output_bus      = mbo_r;
    assign mem_strobe             = strobe_r;
    assign buffer_load_pulse      = bload_r;
    assign mem_write              = mwr_r;
    assign bus_transfer_inhibit_n = inh_n_r;
    assign processor_running      = run_r;
endmodule : akc_datapath
`default_nettype wire

// ==== tb/akc_datapath_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module akc_datapath_checker #(
    parameter int DW = 16
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [7:0]    paddr,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic [DW-2:0] memory_address_reg,
    input wire logic [DW-1:0] memory_buffer_reg,
    input wire logic [DW-1:0] memory_output_bus,
    input wire logic          mem_strobe,
    input wire logic          buffer_load_pulse,
    input wire logic          mem_write,
    input wire logic          bus_transfer_inhibit_n,
    input wire logic          processor_running
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pready_after_setup; psel && !penable |=> pready; endproperty
    property p_pready_in_access; pready |-> psel && penable; endproperty
    property p_slverr_decode;
        pready |-> pslverr == (paddr > 8'h2C || paddr[1:0] != 2'h0);
    endproperty
    property p_strobe_single; mem_strobe |=> !mem_strobe; endproperty
    property p_strobe_excl; mem_strobe |-> !buffer_load_pulse && !mem_write; endproperty
    property p_write_after_load; mem_write |-> $past(buffer_load_pulse); endproperty
    property p_bload_capture;
        buffer_load_pulse |-> memory_buffer_reg == memory_output_bus;
    endproperty
    property p_ma_capture;
        $changed(memory_address_reg) |->
            processor_running && memory_address_reg == memory_output_bus[DW-2:0];
    endproperty
    property p_inhibit_running; !bus_transfer_inhibit_n |-> processor_running; endproperty
    property p_inhibit_release;
        $fell(bus_transfer_inhibit_n) |-> ##[1:10] bus_transfer_inhibit_n;
    endproperty
    a_pready_after_setup: assert property (p_pready_after_setup) else $error("no ready");
    a_pready_in_access: assert property (p_pready_in_access) else $error("stray ready");
    a_slverr_decode: assert property (p_slverr_decode) else $error("bad error flag");
    a_strobe_single: assert property (p_strobe_single) else $error("long strobe");
    a_strobe_excl: assert property (p_strobe_excl) else $error("strobe clash");
    a_write_after_load: assert property (p_write_after_load) else $error("bad write");
    a_bload_capture: assert property (p_bload_capture) else $error("bad buffer");
    a_ma_capture: assert property (p_ma_capture) else $error("bad address");
    a_inhibit_running: assert property (p_inhibit_running) else $error("bad inhibit");
    a_inhibit_release: assert property (p_inhibit_release) else $error("stuck inhibit");
    c_strobe: cover property (mem_strobe);
    c_write: cover property (mem_write);
    c_inhibit: cover property ($fell(bus_transfer_inhibit_n));
endmodule : akc_datapath_checker
bind akc_datapath akc_datapath_checker #(.DW(DW)) akc_datapath_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .memory_address_reg(memory_address_reg),
    .memory_buffer_reg(memory_buffer_reg), .memory_output_bus(memory_output_bus),
    .mem_strobe(mem_strobe), .buffer_load_pulse(buffer_load_pulse), .mem_write(mem_write),
    .bus_transfer_inhibit_n(bus_transfer_inhibit_n), .processor_running(processor_running));
`default_nettype wire

// ==== tb/akc_core_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module akc_core_mem (
    input wire logic        pclk,
    input wire logic [14:0] memory_address_reg,
    input wire logic [15:0] memory_buffer_reg,
    input wire logic        mem_write,
    input wire logic        processor_running,
    output logic     [15:0] mem_sense_data
);
    logic [15:0] mem_r [16];
    logic [15:0] idle_r = 16'h5A5A;
    initial begin
        for (int i = 0; i < 16; i++) mem_r[i] = 16'hA000 + 16'(i);
    end
    always @(posedge pclk) begin
        idle_r <= ~idle_r;
        if (mem_write) mem_r[memory_address_reg[3:0]] <= memory_buffer_reg;
    end
    // stopped core shows a toggling pattern
    assign mem_sense_data = processor_running ? mem_r[memory_address_reg[3:0]] : idle_r;
endmodule : akc_core_mem
`default_nettype wire

// ==== tb/akc_datapath_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module akc_datapath_tb;
    localparam logic [15:0] A = 16'h8421;
    localparam logic [15:0] B = 16'h9234;
    localparam logic [15:0] Q = 16'h00F0;
    localparam logic [31:0] SH = 32'h0001_4000;
    localparam int N = 16;
    localparam logic [31:0] CT [N] = '{SH | 32'h1F, SH | 32'h01, SH | 32'h04, SH | 32'h23,
        SH | 32'h5C, SH | 32'h0C, SH | 32'h83, SH | 32'h11F, SH | 32'hA1F, SH | 32'hC1F,
        SH | 32'hE1F, SH | 32'h61F, SH | 32'h1F, 32'h1C, 32'hC000, 32'h201C};
    localparam logic [15:0] EX [N] = '{16'h1655, 16'h1655, Q, 16'h7BDE, 16'h6D34, 16'h92F0,
        16'h8422, 16'h8020, 16'h2CAB, 16'h8B2A, 16'h5516, 16'h1655, B, B, 16'h9235, 16'h9237};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        data_channel_cycle = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] mem_sense_data;
    logic [14:0] memory_address_reg;
    logic [15:0] memory_buffer_reg;
    logic        mem_write;
    logic        processor_running;
    logic [31:0] r;
    logic        e;
    int          err_count = 0;
    int          checked = 0;
    always #5 pclk = ~pclk;
    akc_datapath #(.DW(16)) akc_datapath_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_sense_data(mem_sense_data), .data_channel_cycle(data_channel_cycle),
        .memory_address_reg(memory_address_reg), .memory_buffer_reg(memory_buffer_reg),
        .memory_output_bus(), .mem_strobe(), .buffer_load_pulse(), .mem_write(mem_write),
        .bus_transfer_inhibit_n(), .processor_running(processor_running));
    akc_core_mem akc_core_mem_i (
        .pclk(pclk), .memory_address_reg(memory_address_reg),
        .memory_buffer_reg(memory_buffer_reg), .mem_write(mem_write),
        .processor_running(processor_running), .mem_sense_data(mem_sense_data));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd_o, output logic err_o);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_o = prdata;
        err_o = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask : rd
    task automatic key(input logic [31:0] k);
        int n = 0;
        wr(8'h08, k);
        repeat (3) @(posedge pclk);
        while (processor_running === 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, processor_running}, 32'h0);
    endtask : key
    // limit well above the few hundred cycles the tests need
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0000_4000);
        apb(1'b0, 8'h30, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        wr(8'h0C, {16'h0, A});
        wr(8'h10, {16'h0, B});
        wr(8'h14, {16'h0, Q});
        rd(8'h0C, {16'h0, A});
        $display("test registers done");
        for (int i = 0; i < N; i++) begin
            data_channel_cycle <= (i == 12);
            wr(8'h00, CT[i]);
            key(32'h4);
            rd((i > 12) ? 8'h1C : 8'h20, {16'h0, EX[i]});
        end
        data_channel_cycle <= 1'b0;
        $display("test alu done");
        wr(8'h04, 32'h5);
        key(32'h1);
        rd(8'h1C, 32'h5);
        rd(8'h24, 32'h5);
        rd(8'h28, 32'hA005);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk(r & 32'h6, 32'h0);
        wr(8'h04, 32'h5A3C);
        key(32'h2);
        rd(8'h20, 32'h5A3C);
        rd(8'h28, 32'h5A3C);
        rd(8'h24, 32'h5);
        chk({16'h0, akc_core_mem_i.mem_r[5]}, 32'h5A3C);
        wr(8'h04, 32'h5);
        key(32'h1);
        rd(8'h28, 32'h5A3C);
        $display("test console done");
        give_verdict();
    end
endmodule : akc_datapath_tb
`default_nettype wire
